/* dmt_pkg.sv */
/*
 * Shared constants and carrier types for the data-memory decode and
 * timing block: the data-space map, the nonvolatile store geometry,
 * stall counts and the request, peripheral and external bus structs.
 * Assumes one core clock and a core that issues one access at a time.
 */
package dmt_pkg;

   // ----------------------------------------------------------------
   // Data-space map
   // ----------------------------------------------------------------
   localparam logic [15:0] IO_BASE = 16'h0020;
   localparam logic [15:0] XIO_BASE = 16'h0060;
   localparam logic [15:0] SRAM_BASE_NORM = 16'h0100;
   localparam logic [15:0] SRAM_BASE_COMPAT = 16'h0060;
   localparam logic [15:0] SRAM_END_NORM = 16'h1100;
   localparam logic [15:0] SRAM_END_COMPAT = 16'h1000;
   localparam int SRAM_WORDS = 4096;
   localparam int SRAM_AW = 12;
   localparam logic [5:0] IO_PORT_MASK = 6'h3f;
   localparam logic [4:0] PTR_REG_LO = 5'h1a;

   // Program memory: 64K words of 16 bits, 16-bit program counter
   localparam int PM_WORDS = 65536;
   localparam int PC_W = 16;

   // ----------------------------------------------------------------
   // Nonvolatile data store and timing
   // ----------------------------------------------------------------
   localparam int NV_BYTES = 4096;
   localparam int NV_AW = 12;
   localparam logic [2:0] NV_RD_STALL = 3'h4;
   localparam logic [2:0] NV_WR_STALL = 3'h2;
   localparam int WS_W = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      RG_NONE, RG_REGF, RG_IO, RG_XIO, RG_SRAM, RG_EXT
   } dmt_region_t;

   typedef enum logic [2:0] {
      AM_DIRECT, AM_DISP, AM_IND, AM_PREDEC, AM_POSTINC
   } dmt_amode_t;

   typedef enum logic [1:0] {PT_X, PT_Y, PT_Z} dmt_ptr_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic two_byte;
      logic io_port;
      dmt_amode_t mode;
      dmt_ptr_t ptr;
      logic [15:0] direct;
      logic [5:0] disp;
      logic [15:0] wdata;
   } dmt_req_t;

   typedef struct packed {
      logic sel;
      dmt_region_t region;
      logic [7:0] addr;
      logic write;
      logic [7:0] wdata;
   } dmt_periph_t;

   typedef struct packed {
      logic wr;
      logic [4:0] reg_lo;
      logic [15:0] val;
   } dmt_ptrupd_t;

   typedef struct packed {
      logic [7:0] ad_o;
      logic ad_oe;
      logic [7:0] a_hi;
      logic ale;
      logic rd_n;
      logic wr_n;
   } dmt_xbus_t;

endpackage

/* dmt_ram.sv */
/*
 * Byte-wide synchronous memory with one write port and two read ports
 * whose data come out of registers.
 * Assumes addresses are in range; contents are not reset.
 */
`timescale 1ns/1ps
module dmt_ram #(
   parameter int AW = 12,
   parameter int DEPTH = 4096
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [AW-1:0] raddr_a,
   input wire logic [AW-1:0] raddr_b,
   output logic [7:0] rdata_a_r,
   output logic [7:0] rdata_b_r
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata_a_r <= mem[raddr_a];
      rdata_b_r <= mem[raddr_b];
   end
endmodule

/* dmt_agu.sv */
/*
 * Data address generator: forms the effective address for the five
 * data addressing modes and the short I/O-port form, and the pointer
 * write-back for pre-decrement and post-increment.
 * Assumes the core supplies the X, Y and Z pointer pair values.
 */
`timescale 1ns/1ps
module dmt_agu
   import dmt_pkg::*;
(
   input wire dmt_req_t req,
   input wire logic [15:0] ptr_x,
   input wire logic [15:0] ptr_y,
   input wire logic [15:0] ptr_z,
   output dmt_region_t unused_region,
   output logic [15:0] ea,
   output dmt_ptrupd_t upd
);
   logic [15:0] base;

   assign unused_region = RG_NONE;

   always_comb begin
      unique case (req.ptr)
         PT_X: base = ptr_x;
         PT_Y: base = ptr_y;
         PT_Z: base = ptr_z;
         default: base = ptr_z;
      endcase
   end

   always_comb begin
      upd.wr = 1'b0;
      upd.reg_lo = PTR_REG_LO + {2'h0, req.ptr, 1'b0};
      upd.val = base;
      ea = req.direct;
      if (req.io_port) begin
         ea = {10'h000, req.direct[5:0] & IO_PORT_MASK} + IO_BASE;
      end else begin
         unique case (req.mode)
            AM_DIRECT: ea = req.direct;
            AM_DISP: ea = base + {10'h000, req.disp};
            AM_IND: ea = base;
            AM_PREDEC: begin
               ea = base - 16'h0001;
               upd.wr = 1'b1;
               upd.val = base - 16'h0001;
            end
            AM_POSTINC: begin
               ea = base;
               upd.wr = 1'b1;
               upd.val = base + 16'h0001;
            end
            default: ea = req.direct;
         endcase
      end
   end
endmodule

/* dmt_core.sv */
/*
 * Data-memory decode and access timing. Routes each mapped core data access
 * to the register file, standard or extended I/O, internal SRAM or an
 * external SRAM on the multiplexed bus, adds external and wait-state
 * cycles, and stalls the core around nonvolatile byte accesses.
 * Assumes the core issues a request only while access_busy_r is low,
 * and that register-file and I/O read data are valid in the cycle
 * the select is high.
 */
`timescale 1ns/1ps
module dmt_core
   import dmt_pkg::*;
#(
   parameter int NV_WR_CYCLES = 1024
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic legacy_mode,
   input wire logic external_memory_enable_bit,
   input wire logic [WS_W-1:0] wait_states,
   input wire dmt_req_t req,
   input wire logic [15:0] ptr_x,
   input wire logic [15:0] ptr_y,
   input wire logic [15:0] ptr_z,
   input wire logic [7:0] periph_rdata,
   input wire logic [7:0] ad_i,
   input wire logic nv_read,
   input wire logic nv_write,
   input wire logic [NV_AW-1:0] nv_addr,
   input wire logic [7:0] nv_wdata,
   output logic access_busy_r,
   output logic done_r,
   output logic [15:0] rdata_r,
   output dmt_periph_t periph_r,
   output dmt_ptrupd_t ptr_upd_r,
   output dmt_xbus_t xbus_r,
   output logic [7:0] nv_rdata_r,
   output logic nv_busy_r,
   output logic core_stall_r
);
   typedef enum logic [1:0] {ST_IDLE, ST_INT, ST_ALE, ST_STB} dmt_state_t;

   localparam logic [15:0] NV_WR_LAST = 16'(NV_WR_CYCLES - 1);

   dmt_state_t state_r, state_nxt;
   dmt_region_t region_r, rg_nxt;
   logic [15:0] ea, ea_r, addr_nxt, sram_off;
   logic [15:0] wdata_r;
   logic [WS_W-1:0] ws_r, stb_cnt_r;
   logic two_r, write_r, byte_r, acc, stb_last;
   logic [7:0] ram_a, ram_b;
   logic ram_we;
   logic [SRAM_AW-1:0] ram_waddr, ram_idx;
   logic [7:0] ram_wdata;
   dmt_ptrupd_t upd;
   logic [2:0] nv_cnt_r, nv_cnt_nxt;
   logic [15:0] nv_tmr_r;
   logic [NV_AW-1:0] nv_waddr_r;
   logic [7:0] nv_wdata_r, nv_dout;
   logic nv_rd_go, nv_wr_go, nv_commit;

   // ----------------------------------------------------------------
   // Address generation and region decode
   // ----------------------------------------------------------------
   dmt_agu u_agu (
      .req(req),
      .ptr_x(ptr_x),
      .ptr_y(ptr_y),
      .ptr_z(ptr_z),
      .unused_region(),
      .ea(ea),
      .upd(upd)
   );

   function automatic dmt_region_t decode(input logic [15:0] a,
                                          input logic compat,
                                          input logic xen);
      if (a < IO_BASE) begin
         return RG_REGF;
      end else if (a < XIO_BASE) begin
         return RG_IO;
      end else if (!compat && a < SRAM_BASE_NORM) begin
         return RG_XIO;
      end else if (a < (compat ? SRAM_END_COMPAT : SRAM_END_NORM)) begin
         return RG_SRAM;
      end else if (xen) begin
         return RG_EXT;
      end
      // Upper space with the bus off is a hole, never folded back
      return RG_NONE;
   endfunction

   assign rg_nxt = decode(ea, legacy_mode, external_memory_enable_bit);
   assign acc = req.valid && state_r == ST_IDLE;
   assign sram_off = ea - (legacy_mode ? SRAM_BASE_COMPAT : SRAM_BASE_NORM);
   assign ram_idx = sram_off[SRAM_AW-1:0];
   assign stb_last = state_r == ST_STB && stb_cnt_r == ws_r;

   // ----------------------------------------------------------------
   // Access sequencing
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      addr_nxt = ea_r;
      unique case (state_r)
         ST_IDLE: begin
            addr_nxt = ea;
            if (acc) begin
               state_nxt = (rg_nxt == RG_EXT) ? ST_ALE : ST_INT;
            end
         end
         ST_INT: state_nxt = ST_IDLE;
         ST_ALE: state_nxt = ST_STB;
         ST_STB: begin
            if (stb_last) begin
               // Second byte of a stacked return address goes out again
               if (two_r && !byte_r) begin
                  state_nxt = ST_ALE;
                  addr_nxt = ea_r + 16'h0001;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         access_busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         access_busy_r <= state_nxt != ST_IDLE;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         region_r <= RG_NONE;
         ea_r <= 16'h0000;
         wdata_r <= 16'h0000;
         ws_r <= '0;
         two_r <= 1'b0;
         write_r <= 1'b0;
         byte_r <= 1'b0;
         stb_cnt_r <= '0;
      end else begin
         if (acc) begin
            region_r <= rg_nxt;
            wdata_r <= req.wdata;
            ws_r <= wait_states;
            two_r <= req.two_byte;
            write_r <= req.write;
            byte_r <= 1'b0;
         end else if (stb_last) begin
            byte_r <= 1'b1;
         end
         ea_r <= addr_nxt;
         stb_cnt_r <= (state_r == ST_STB) ? stb_cnt_r + 1'b1 : '0;
      end
   end

   // ----------------------------------------------------------------
   // Completion and read data
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         done_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         done_r <= (state_r == ST_INT) ||
                   (stb_last && !(two_r && !byte_r));
         if (state_r == ST_INT) begin
            unique case (region_r)
               RG_SRAM: rdata_r <= {ram_b, ram_a};
               RG_REGF, RG_IO, RG_XIO: rdata_r <= {8'h00, periph_rdata};
               default: rdata_r <= 16'h0000;
            endcase
         end else if (stb_last && !write_r) begin
            if (byte_r) begin
               rdata_r[15:8] <= ad_i;
            end else begin
               rdata_r[7:0] <= ad_i;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Register file and I/O selects, pointer write-back
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         periph_r <= '0;
         ptr_upd_r <= '0;
      end else begin
         periph_r.sel <= acc && (rg_nxt == RG_REGF || rg_nxt == RG_IO ||
                                 rg_nxt == RG_XIO);
         periph_r.region <= rg_nxt;
         periph_r.addr <= ea[7:0];
         periph_r.write <= req.write;
         periph_r.wdata <= req.wdata[7:0];
         ptr_upd_r.wr <= acc && upd.wr;
         ptr_upd_r.reg_lo <= upd.reg_lo;
         ptr_upd_r.val <= upd.val;
      end
   end

   // ----------------------------------------------------------------
   // Internal SRAM
   // ----------------------------------------------------------------
   // Both bytes are read at once so a two-byte pop stays at two cycles
   always_comb begin
      ram_we = 1'b0;
      ram_waddr = ram_idx;
      ram_wdata = req.wdata[7:0];
      if (acc && rg_nxt == RG_SRAM && req.write) begin
         ram_we = 1'b1;
      end else if (state_r == ST_INT && region_r == RG_SRAM && two_r &&
                   write_r) begin
         ram_we = 1'b1;
         ram_waddr = ea_r[SRAM_AW-1:0] + 1'b1;
         ram_wdata = wdata_r[15:8];
      end
   end

   dmt_ram #(.AW(SRAM_AW), .DEPTH(SRAM_WORDS)) u_sram (
      .clk(mclk),
      .we(ram_we),
      .waddr(ram_waddr),
      .wdata(ram_wdata),
      .raddr_a(ram_idx),
      .raddr_b(ram_idx + 1'b1),
      .rdata_a_r(ram_a),
      .rdata_b_r(ram_b)
   );

   // ----------------------------------------------------------------
   // External bus
   // ----------------------------------------------------------------
   // Strobes only move while an external access is in flight
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         xbus_r <= '{ad_o: 8'h00, ad_oe: 1'b0, a_hi: 8'h00, ale: 1'b0,
                     rd_n: 1'b1, wr_n: 1'b1};
      end else begin
         xbus_r.ale <= state_nxt == ST_ALE;
         xbus_r.rd_n <= !(state_nxt == ST_STB && !write_r);
         xbus_r.wr_n <= !(state_nxt == ST_STB && write_r);
         if (state_nxt == ST_ALE) begin
            xbus_r.ad_o <= addr_nxt[7:0];
            xbus_r.a_hi <= addr_nxt[15:8];
            xbus_r.ad_oe <= 1'b1;
         end else if (state_nxt == ST_STB) begin
            xbus_r.ad_o <= byte_r ? wdata_r[15:8] : wdata_r[7:0];
            xbus_r.ad_oe <= write_r;
         end else begin
            xbus_r.ad_oe <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Nonvolatile data store
   // ----------------------------------------------------------------
   assign nv_rd_go = nv_read && !nv_busy_r && nv_cnt_r == 3'h0;
   assign nv_wr_go = nv_write && !nv_busy_r && nv_cnt_r == 3'h0;
   assign nv_commit = nv_busy_r && nv_tmr_r == 16'h0000;

   always_comb begin
      nv_cnt_nxt = (nv_cnt_r != 3'h0) ? nv_cnt_r - 3'h1 : 3'h0;
      if (nv_rd_go) begin
         nv_cnt_nxt = NV_RD_STALL;
      end else if (nv_wr_go) begin
         nv_cnt_nxt = NV_WR_STALL;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         nv_cnt_r <= 3'h0;
         core_stall_r <= 1'b0;
      end else begin
         nv_cnt_r <= nv_cnt_nxt;
         core_stall_r <= nv_cnt_nxt != 3'h0;
      end
   end

   // Write completes on its own timer; software polls nv_busy_r
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         nv_busy_r <= 1'b0;
         nv_tmr_r <= 16'h0000;
         nv_waddr_r <= '0;
         nv_wdata_r <= 8'h00;
      end else if (nv_wr_go) begin
         nv_busy_r <= 1'b1;
         nv_tmr_r <= NV_WR_LAST;
         nv_waddr_r <= nv_addr;
         nv_wdata_r <= nv_wdata;
      end else if (nv_commit) begin
         nv_busy_r <= 1'b0;
      end else if (nv_busy_r) begin
         nv_tmr_r <= nv_tmr_r - 16'h0001;
      end
   end

   dmt_ram #(.AW(NV_AW), .DEPTH(NV_BYTES)) u_nvram (
      .clk(mclk),
      .we(nv_commit),
      .waddr(nv_waddr_r),
      .wdata(nv_wdata_r),
      .raddr_a(nv_addr),
      .raddr_b(nv_addr),
      .rdata_a_r(nv_dout),
      .rdata_b_r()
   );

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         nv_rdata_r <= 8'h00;
      end else if (nv_cnt_r == NV_RD_STALL) begin
         nv_rdata_r <= nv_dout;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sequence s_ext_addr;
      xbus_r.ale && xbus_r.rd_n && xbus_r.wr_n;
   endsequence

   sequence s_ext_strobe;
      !xbus_r.ale && (xbus_r.rd_n != xbus_r.wr_n);
   endsequence

   sequence s_int_quiet;
      (xbus_r.rd_n && xbus_r.wr_n)[*3];
   endsequence

   int_quiet_a: assert property (
      (acc && rg_nxt != RG_EXT) |-> s_int_quiet and (##2 done_r))
      else $error("internal access moved a strobe or missed timing");

   int_two_cycle_a: assert property (
      (acc && rg_nxt == RG_SRAM) |-> ##1 !done_r ##1 done_r)
      else $error("internal SRAM access not done in two cycles");

   ext_phase_a: assert property (
      (acc && rg_nxt == RG_EXT && wait_states == 2'h0 && !req.two_byte)
      |-> ##1 s_ext_addr ##1 s_ext_strobe ##1 done_r)
      else $error("zero-wait external byte timing wrong");

   ext_wait_two_a: assert property (
      (acc && rg_nxt == RG_EXT && wait_states == 2'h2 && !req.two_byte)
      |-> ##1 !done_r[*4] ##1 done_r)
      else $error("two-wait external byte timing wrong");

   ext_stack_nowait_a: assert property (
      (acc && rg_nxt == RG_EXT && wait_states == 2'h0 && req.two_byte)
      |-> ##1 !done_r[*4] ##1 done_r)
      else $error("external two-byte transfer not five cycles");

   ext_stack_wait_a: assert property (
      (acc && rg_nxt == RG_EXT && wait_states == 2'h3 && req.two_byte)
      |-> ##11 done_r)
      else $error("three-wait external two-byte transfer wrong");

   no_alias_a: assert property (
      (acc && !external_memory_enable_bit && ea >= SRAM_END_NORM)
      |-> ##2 (done_r && rdata_r == 16'h0000))
      else $error("disabled external space aliased");

   legacy_map_a: assert property (
      (acc && legacy_mode) |-> (rg_nxt != RG_XIO &&
      (ea < SRAM_END_COMPAT || rg_nxt inside {RG_EXT, RG_NONE})))
      else $error("legacy mode decoded extended I/O or wrong top");

   nv_read_stall_a: assert property (
      nv_rd_go |=> core_stall_r[*4] ##1 !core_stall_r)
      else $error("nonvolatile read stall not four cycles");

   nv_write_stall_a: assert property (
      nv_wr_go |=> (core_stall_r && nv_busy_r)[*2] ##1 !core_stall_r)
      else $error("nonvolatile write stall not two cycles");

   ptr_update_a: assert property (
      (acc && req.mode == AM_POSTINC && !req.io_port)
      |=> (ptr_upd_r.wr && ptr_upd_r.val == $past(upd.val)))
      else $error("post-increment pointer not written back");
endmodule

/* dmt_xsram.sv */
/*
 * External asynchronous SRAM behind its address latch, for the
 * multiplexed bus of the data-memory decode block.
 * Assumes strobes are held at least one full core clock cycle.
 */
`timescale 1ns/1ps
module dmt_xsram
   import dmt_pkg::*;
(
   input wire logic mclk,
   input wire dmt_xbus_t xbus,
   output logic [7:0] ad_i
);
   logic [7:0] mem [0:65535];
   logic [15:0] lat_r;
   logic [7:0] last_r;
   always @(posedge mclk) begin
      if (xbus.ale === 1'b1)
         lat_r <= {xbus.a_hi, xbus.ad_o};
      if (xbus.wr_n === 1'b0)
         mem[lat_r] <= xbus.ad_o;
      if (xbus.rd_n === 1'b0)
         last_r <= mem[lat_r];
   end
   // Released bus shows the inverse of the last byte, never a clean hold
   assign ad_i = (xbus.rd_n === 1'b0) ? mem[lat_r] : ~last_r;
endmodule

/* data_memory_decode_and_timing_tb.sv */
/*
 * Self-checking bench for dmt_core with an external SRAM model.
 * Assumes the short nonvolatile write time of 8 cycles set below.
 */
`timescale 1ns/1ps
module data_memory_decode_and_timing_tb
   import dmt_pkg::*;
;
   logic mclk, nrst, legacy_mode, xen, nv_read, nv_write;
   logic [1:0] ws;
   dmt_req_t req;
   logic [15:0] px, py, pz, rdata;
   logic [7:0] ad_i, nv_wdata, nv_rdata;
   logic [11:0] nv_addr;
   logic busy, done, nv_busy, stall, st;
   dmt_periph_t periph, psel;
   dmt_ptrupd_t upd, pu;
   dmt_xbus_t xbus;
   int n_mismatch, comparisons, cyc;

   dmt_core #(.NV_WR_CYCLES(8)) u_dut (.mclk(mclk), .nrst(nrst),
      .legacy_mode(legacy_mode), .external_memory_enable_bit(xen),
      .wait_states(ws), .req(req), .ptr_x(px), .ptr_y(py), .ptr_z(pz),
      .periph_rdata(8'ha5), .ad_i(ad_i), .nv_read(nv_read),
      .nv_write(nv_write), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
      .access_busy_r(busy), .done_r(done), .rdata_r(rdata),
      .periph_r(periph), .ptr_upd_r(upd), .xbus_r(xbus),
      .nv_rdata_r(nv_rdata), .nv_busy_r(nv_busy), .core_stall_r(stall));
   dmt_xsram u_xsram (.mclk(mclk), .xbus(xbus), .ad_i(ad_i));

   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end

   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // One data access; records latency, strobes, peripheral select
   // ----------------------------------------------------------------
   task automatic acc(input logic wr, input logic two, input logic io,
         input dmt_amode_t m, input dmt_ptr_t p, input logic [15:0] a,
         input logic [5:0] d, input logic [15:0] wd);
      int nb;
      @(posedge mclk);
      req <= '{1'b1, wr, two, io, m, p, a, d, wd};
      cyc = 0;
      st = 0;
      psel = '0;
      pu = '0;
      nb = 0;
      do begin
         @(posedge mclk);
         req.valid <= 1'b0;
         #1;
         cyc++;
         if (xbus.rd_n !== 1'b1 || xbus.wr_n !== 1'b1) st = 1;
         if (periph.sel === 1'b1) psel = periph;
         if (upd.wr === 1'b1) pu = upd;
         if (busy === 1'b1) nb++;
      end while (done !== 1'b1 && cyc < 40);
      if (cyc >= 40) begin
         n_mismatch++;
         end_sim();
      end
      // Busy covers every cycle between acceptance and completion
      chk(nb, cyc - 1);
   endtask

   task automatic rd(input logic [15:0] a, input logic two);
      acc(0, two, 0, AM_DIRECT, PT_X, a, 6'h00, 16'h0000);
   endtask

   task automatic wr(input logic [15:0] a, input logic two,
         input logic [15:0] wd);
      acc(1, two, 0, AM_DIRECT, PT_X, a, 6'h00, wd);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_map();
      logic [15:0] ad [5] = '{16'h001f, 16'h0020, 16'h005f, 16'h0060,
         16'h00ff};
      dmt_region_t rg [5] = '{RG_REGF, RG_IO, RG_IO, RG_XIO, RG_XIO};
      wr(16'h0100, 0, 16'h0011);
      chk(cyc, 2);
      chk(st, 0);
      wr(16'h10ff, 0, 16'h0022);
      rd(16'h10ff, 0);
      chk(rdata[7:0], 8'h22);
      for (int i = 0; i < 5; i++) begin
         rd(ad[i], 0);
         chk(psel.region, rg[i]);
         chk(psel.addr, ad[i][7:0]);
         chk(rdata[7:0], 8'ha5);
      end
      acc(0, 0, 1, AM_DIRECT, PT_X, 16'h003f, 6'h00, 16'h0000);
      chk(psel.addr, 8'h5f);
      legacy_mode <= 1;
      // Offset 1, so the byte at 0x0100 that later scenarios read survives
      wr(16'h0061, 0, 16'h0033);
      chk(psel.sel, 0);
      rd(16'h0061, 0);
      chk(rdata[7:0], 8'h33);
      legacy_mode <= 0;
   endtask

   task automatic t_unmapped();
      wr(16'h1100, 0, 16'h0077);
      chk(st, 0);
      rd(16'h1100, 0);
      chk(rdata, 0);
      rd(16'h0100, 0);
      chk(rdata[7:0], 8'h11);
   endtask

   // Wait states latched per access, so each loop pass sees its own
   task automatic t_ext();
      xen <= 1;
      for (int w = 0; w < 4; w++) begin
         ws <= w[1:0];
         wr(16'h1100 + w, 0, 16'h0040 + w);
         chk(cyc, 3 + w);
         rd(16'h1100 + w, 0);
         chk(cyc, 3 + w);
         chk(rdata[7:0], 8'h40 + w);
         wr(16'hfffe, 1, 16'hbe00 + w);
         chk(cyc, 5 + 2 * w);
         rd(16'hfffe, 1);
         chk(rdata, 16'hbe00 + w);
      end
      ws <= 0;
      rd(16'h0100, 0);
      chk(st, 0);
      legacy_mode <= 1;
      rd(16'h1000, 0);
      chk(st, 1);
      legacy_mode <= 0;
      xen <= 0;
   endtask

   task automatic t_ptr();
      px <= 16'h0200;
      pz <= 16'h0101;
      py <= 16'h00c1;
      acc(0, 0, 0, AM_POSTINC, PT_X, 16'h0000, 6'h00, 16'h0000);
      chk(pu.reg_lo, 5'h1a);
      chk(pu.val, 16'h0201);
      acc(0, 0, 0, AM_PREDEC, PT_Z, 16'h0000, 6'h00, 16'h0000);
      chk(pu.reg_lo, 5'h1e);
      chk(pu.val, 16'h0100);
      chk(rdata[7:0], 8'h11);
      acc(0, 0, 0, AM_DISP, PT_Y, 16'h0000, 6'h3f, 16'h0000);
      chk(rdata[7:0], 8'h11);
   endtask

   task automatic nv(input logic w, input logic [7:0] d, input int es);
      int n;
      int b;
      @(posedge mclk);
      nv_write <= w;
      nv_read <= !w;
      nv_addr <= 12'hfff;
      nv_wdata <= d;
      n = 0;
      b = 0;
      repeat (20) begin
         @(posedge mclk);
         nv_write <= 0;
         nv_read <= 0;
         #1;
         n += stall;
         b += nv_busy;
      end
      chk(n, es);
      chk(b, w ? 8 : 0);
      if (!w) chk(nv_rdata, d);
   endtask

   initial begin
      {nrst, legacy_mode, xen, nv_read, nv_write, ws} = '0;
      {px, py, pz, nv_addr, nv_wdata} = '0;
      req = '0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (2) @(posedge mclk);
      nrst <= 1;
      t_map();
      t_unmapped();
      t_ext();
      t_ptr();
      nv(1, 8'h5a, 2);
      nv(0, 8'h5a, 4);
      end_sim();
   end
endmodule
